// >>> core/sdmrf_pkg.sv
`default_nettype none

package sdmrf_pkg;

  // ----------------------------------------
  // Mode addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_LATENCY_SELECT = 8'h02;
  localparam logic [7:0] ADDR_IO_DRIVE       = 8'h03;
  localparam logic [7:0] ADDR_TEMP_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_MAKER_ID       = 8'h05;
  localparam logic [7:0] ADDR_DIE_REV        = 8'h06;
  localparam logic [7:0] ADDR_SECOND_REV     = 8'h07;
  localparam logic [7:0] ADDR_GEOMETRY       = 8'h08;
  localparam logic [7:0] ADDR_VENDOR_TEST    = 8'h09;
  localparam logic [7:0] ADDR_CALIBRATION    = 8'h0a;

  // ----------------------------------------
  // Reset values and field positions
  // ----------------------------------------
  localparam logic [3:0] LATENCY_RESET  = 4'h1;
  localparam logic [3:0] DRIVE_RESET    = 4'h2;
  localparam int         TUF_BIT        = 7;
  localparam int         HOT_BIT        = 2;
  localparam int         TYPE_LSB       = 0;
  localparam int         DENSITY_LSB    = 2;
  localparam int         WIDTH_LSB      = 6;

  // ----------------------------------------
  // Latency and drive codes
  // ----------------------------------------
  localparam logic [3:0] LAT_MIN = 4'h1;
  localparam logic [3:0] LAT_MAX = 4'h6;
  localparam logic [3:0] DRV_MIN = 4'h1;
  localparam logic [3:0] DRV_MAX = 4'h7;
  localparam logic [3:0] DRV_RSVD = 4'h5;

  // ----------------------------------------
  // Refresh-rate status codes
  // ----------------------------------------
  localparam logic [2:0] RATE_LOW_LIMIT  = 3'h0;
  localparam logic [2:0] RATE_X4         = 3'h1;
  localparam logic [2:0] RATE_X2         = 3'h2;
  localparam logic [2:0] RATE_X1         = 3'h3;
  localparam logic [2:0] RATE_RSVD       = 3'h4;
  localparam logic [2:0] RATE_QTR_NODR   = 3'h5;
  localparam logic [2:0] RATE_QTR_DERATE = 3'h6;
  localparam logic [2:0] RATE_HIGH_LIMIT = 3'h7;

  // ----------------------------------------
  // Calibration commands
  // ----------------------------------------
  typedef enum logic [1:0] {
    SDMRF_CAL_INIT  = 2'b00,
    SDMRF_CAL_LONG  = 2'b01,
    SDMRF_CAL_SHORT = 2'b10,
    SDMRF_CAL_RESET = 2'b11
  } sdmrf_cal_t;

  localparam logic [7:0] CAL_CODE_INIT  = 8'hff;
  localparam logic [7:0] CAL_CODE_LONG  = 8'hab;
  localparam logic [7:0] CAL_CODE_SHORT = 8'h56;
  localparam logic [7:0] CAL_CODE_RESET = 8'hc3;

  // Mode register command from the controller
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] mode_address;
    logic [7:0] opcode_bits;
  } sdmrf_cmd_t;

  // Decoded latency pair
  typedef struct packed {
    logic [3:0] read_latency;
    logic [3:0] write_latency;
  } sdmrf_lat_t;

endpackage : sdmrf_pkg

`default_nettype wire

// >>> core/sdmrf_regfile.sv
`timescale 1ns/1ps
`default_nettype none

module sdmrf_regfile #(
  parameter logic [7:0] MAKER_CODE   = 8'h5a,  // Arbitrary value
  parameter logic [7:0] DIE_REV_CODE = 8'h11,  // Arbitrary value
  parameter logic [7:0] REV2_CODE    = 8'h3e,  // Arbitrary value
  parameter logic [1:0] DEV_TYPE     = 2'h0,
  parameter logic [3:0] DENSITY      = 4'h7,
  parameter logic [1:0] IO_WIDTH     = 2'h0
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire sdmrf_pkg::sdmrf_cmd_t cmd,
  input  wire logic [2:0]            sensor_rate,
  output logic [7:0]                 rd_data,
  output logic                       rd_valid,
  output sdmrf_pkg::sdmrf_lat_t      latency,
  output logic [3:0]                 drive_strength,
  output logic                       cal_start,
  output sdmrf_pkg::sdmrf_cal_t      cal_kind,
  output logic                       derate_timing,
  output logic                       temp_limit_exceeded
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic sdmrf_pkg::sdmrf_lat_t lat_decode(input logic [3:0] code);
    sdmrf_pkg::sdmrf_lat_t l;
    l = '{read_latency: 4'h3, write_latency: 4'h1};
    case (code)
      4'h2:    l = '{read_latency: 4'h4, write_latency: 4'h2};
      4'h3:    l = '{read_latency: 4'h5, write_latency: 4'h2};
      4'h4:    l = '{read_latency: 4'h6, write_latency: 4'h3};
      4'h5:    l = '{read_latency: 4'h7, write_latency: 4'h4};
      4'h6:    l = '{read_latency: 4'h8, write_latency: 4'h4};
      default: l = '{read_latency: 4'h3, write_latency: 4'h1};
    endcase
    return l;
  endfunction : lat_decode

  function automatic logic drv_legal(input logic [3:0] code);
    return (code >= sdmrf_pkg::DRV_MIN) && (code <= sdmrf_pkg::DRV_MAX) &&
           (code != sdmrf_pkg::DRV_RSVD);
  endfunction : drv_legal

  // ----------------------------------------
  // Legality and read-back helpers
  // ----------------------------------------
  function automatic logic lat_legal(input logic [3:0] code);
    return (code >= sdmrf_pkg::LAT_MIN) && (code <= sdmrf_pkg::LAT_MAX);
  endfunction : lat_legal

  function automatic logic cal_legal(input logic [7:0] code);
    return (code == sdmrf_pkg::CAL_CODE_INIT) || (code == sdmrf_pkg::CAL_CODE_LONG) ||
           (code == sdmrf_pkg::CAL_CODE_SHORT) || (code == sdmrf_pkg::CAL_CODE_RESET);
  endfunction : cal_legal

  function automatic sdmrf_pkg::sdmrf_cal_t cal_decode(input logic [7:0] code);
    sdmrf_pkg::sdmrf_cal_t k;
    k = sdmrf_pkg::SDMRF_CAL_INIT;
    case (code)
      sdmrf_pkg::CAL_CODE_INIT:  k = sdmrf_pkg::SDMRF_CAL_INIT;
      sdmrf_pkg::CAL_CODE_LONG:  k = sdmrf_pkg::SDMRF_CAL_LONG;
      sdmrf_pkg::CAL_CODE_SHORT: k = sdmrf_pkg::SDMRF_CAL_SHORT;
      sdmrf_pkg::CAL_CODE_RESET: k = sdmrf_pkg::SDMRF_CAL_RESET;
      default:                   k = sdmrf_pkg::SDMRF_CAL_INIT;
    endcase
    return k;
  endfunction : cal_decode

  function automatic logic rate_derates(input logic [2:0] rate);
    return (rate == sdmrf_pkg::RATE_QTR_DERATE);
  endfunction : rate_derates

  function automatic logic rate_at_limit(input logic [2:0] rate);
    return (rate == sdmrf_pkg::RATE_LOW_LIMIT) || (rate == sdmrf_pkg::RATE_HIGH_LIMIT);
  endfunction : rate_at_limit

  function automatic logic [7:0] temp_word(input logic flag, input logic [2:0] rate);
    logic [7:0] w;
    w                     = 8'h00;
    w[sdmrf_pkg::TUF_BIT] = flag;
    w[2:0]                = rate;
    return w;
  endfunction : temp_word

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic wr_lat;
  logic wr_drv;
  logic wr_cal;
  logic rd_temp;

  always_comb begin
    wr_lat  = 1'b0;
    wr_drv  = 1'b0;
    wr_cal  = 1'b0;
    rd_temp = cmd.rd && (cmd.mode_address == sdmrf_pkg::ADDR_TEMP_STATUS);
    if (cmd.wr) begin
      case (cmd.mode_address)
        sdmrf_pkg::ADDR_LATENCY_SELECT: wr_lat = 1'b1;
        sdmrf_pkg::ADDR_IO_DRIVE:       wr_drv = 1'b1;
        sdmrf_pkg::ADDR_CALIBRATION:    wr_cal = 1'b1;
        default:                        wr_lat = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Settings group: latency and drive
  // ----------------------------------------
  logic [3:0] lat_code_r;
  logic [3:0] lat_code_nxt;
  logic [3:0] drive_r;
  logic [3:0] drive_nxt;

  always_comb begin
    lat_code_nxt = lat_code_r;
    drive_nxt    = drive_r;
    // Reserved codes keep the previous setting
    if (wr_lat && lat_legal(cmd.opcode_bits[3:0])) begin
      lat_code_nxt = cmd.opcode_bits[3:0];
    end
    if (wr_drv && drv_legal(cmd.opcode_bits[3:0])) begin
      drive_nxt = cmd.opcode_bits[3:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lat_code_r <= sdmrf_pkg::LATENCY_RESET;
      drive_r    <= sdmrf_pkg::DRIVE_RESET;
    end else begin
      lat_code_r <= lat_code_nxt;
      drive_r    <= drive_nxt;
    end
  end

  // ----------------------------------------
  // Temperature group: stored rate and update flag
  // ----------------------------------------
  logic [2:0] rate_r;
  logic [2:0] rate_nxt;
  logic       tuf_r;
  logic       tuf_nxt;
  logic       rate_chg;

  assign rate_chg = (sensor_rate != rate_r);

  always_comb begin
    rate_nxt = sensor_rate;
    tuf_nxt  = tuf_r;
    // Change wins over a same-cycle read clear
    if (rd_temp) begin
      tuf_nxt = 1'b0;
    end
    if (rate_chg) begin
      tuf_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rate_r <= sdmrf_pkg::RATE_X1;
      tuf_r  <= 1'b0;
    end else begin
      rate_r <= rate_nxt;
      tuf_r  <= tuf_nxt;
    end
  end

  // ----------------------------------------
  // Read group: read-back data and valid
  // ----------------------------------------
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic       rd_valid_r;
  logic       rd_valid_nxt;

  always_comb begin
    rd_valid_nxt = cmd.rd;
    rd_data_nxt  = 8'h00;
    // Read-only registers ignore writes; unlisted addresses read zero
    if (cmd.rd) begin
      case (cmd.mode_address)
        sdmrf_pkg::ADDR_TEMP_STATUS: rd_data_nxt = temp_word(tuf_r, rate_r);
        sdmrf_pkg::ADDR_MAKER_ID:    rd_data_nxt = MAKER_CODE;
        sdmrf_pkg::ADDR_DIE_REV:     rd_data_nxt = DIE_REV_CODE;
        sdmrf_pkg::ADDR_SECOND_REV:  rd_data_nxt = REV2_CODE;
        sdmrf_pkg::ADDR_GEOMETRY: begin
          rd_data_nxt[sdmrf_pkg::TYPE_LSB +: 2]    = DEV_TYPE;
          rd_data_nxt[sdmrf_pkg::DENSITY_LSB +: 4] = DENSITY;
          rd_data_nxt[sdmrf_pkg::WIDTH_LSB +: 2]   = IO_WIDTH;
        end
        default: rd_data_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  // ----------------------------------------
  // Calibration group: start pulse and kind
  // ----------------------------------------
  sdmrf_pkg::sdmrf_cal_t cal_kind_r;
  sdmrf_pkg::sdmrf_cal_t cal_kind_nxt;
  logic                  cal_start_r;
  logic                  cal_start_nxt;

  always_comb begin
    cal_start_nxt = 1'b0;
    cal_kind_nxt  = cal_kind_r;
    // Reserved codes neither pulse nor change the kind
    if (wr_cal && cal_legal(cmd.opcode_bits)) begin
      cal_start_nxt = 1'b1;
      cal_kind_nxt  = cal_decode(cmd.opcode_bits);
    end else if (wr_cal) begin
      cal_start_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cal_start_r <= 1'b0;
      cal_kind_r  <= sdmrf_pkg::SDMRF_CAL_INIT;
    end else begin
      cal_start_r <= cal_start_nxt;
      cal_kind_r  <= cal_kind_nxt;
    end
  end

  // ----------------------------------------
  // Output group: decoded settings and rate status
  // ----------------------------------------
  sdmrf_pkg::sdmrf_lat_t lat_out_r;
  sdmrf_pkg::sdmrf_lat_t lat_out_nxt;
  logic                  derate_r;
  logic                  derate_nxt;
  logic                  limit_r;
  logic                  limit_nxt;

  // Decoded from next values so outputs track the stored state without lag
  always_comb begin
    lat_out_nxt = lat_decode(lat_code_nxt);
    derate_nxt  = rate_derates(rate_nxt);
    limit_nxt   = rate_at_limit(rate_nxt);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lat_out_r <= lat_decode(sdmrf_pkg::LATENCY_RESET);
      derate_r  <= rate_derates(sdmrf_pkg::RATE_X1);
      limit_r   <= rate_at_limit(sdmrf_pkg::RATE_X1);
    end else begin
      lat_out_r <= lat_out_nxt;
      derate_r  <= derate_nxt;
      limit_r   <= limit_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rd_data             = rd_data_r;
  assign rd_valid            = rd_valid_r;
  assign latency             = lat_out_r;
  assign drive_strength      = drive_r;
  assign cal_start           = cal_start_r;
  assign cal_kind            = cal_kind_r;
  assign derate_timing       = derate_r;
  assign temp_limit_exceeded = limit_r;

endmodule : sdmrf_regfile

`default_nettype wire

// >>> tb/sdmrf_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module sdmrf_monitor (
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  input wire sdmrf_pkg::sdmrf_cmd_t cmd,
  input wire logic [2:0]            sensor_rate,
  input wire logic [7:0]            rd_data,
  input wire logic                  rd_valid,
  input wire sdmrf_pkg::sdmrf_lat_t latency,
  input wire logic [3:0]            drive_strength,
  input wire logic                  cal_start,
  input wire logic                  derate_timing,
  input wire logic                  temp_limit_exceeded
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic rd4, wr2, wr3, wcal;
  logic [3:0] op;
  assign op = cmd.opcode_bits[3:0];
  assign rd4 = cmd.rd && cmd.mode_address == sdmrf_pkg::ADDR_TEMP_STATUS;
  assign wr2 = cmd.wr && cmd.mode_address == sdmrf_pkg::ADDR_LATENCY_SELECT;
  assign wr3 = cmd.wr && cmd.mode_address == sdmrf_pkg::ADDR_IO_DRIVE;
  assign wcal = cmd.wr && cmd.mode_address == sdmrf_pkg::ADDR_CALIBRATION
    && cmd.opcode_bits inside {sdmrf_pkg::CAL_CODE_INIT, sdmrf_pkg::CAL_CODE_LONG,
                               sdmrf_pkg::CAL_CODE_SHORT, sdmrf_pkg::CAL_CODE_RESET};
  property p_rdv; rd_valid == $past(cmd.rd); endproperty
  property p_rdz; !rd_valid |-> rd_data == 8'h00; endproperty
  property p_clr; (rd4 && $stable(sensor_rate)) ##1 $stable(sensor_rate) ##1 rd4
    |=> !rd_data[7]; endproperty
  property p_set; ($changed(sensor_rate) && !rd4) ##1 rd4 |=> rd_data[7]; endproperty
  property p_rate; rd_valid && $past(rd4) |-> rd_data[6:0] == {4'h0, $past(sensor_rate, 2)};
  endproperty
  property p_der; derate_timing == ($past(sensor_rate) == 3'h6); endproperty
  property p_lim; temp_limit_exceeded == ($past(sensor_rate) inside {3'h0, 3'h7}); endproperty
  property p_cal; cal_start == $past(wcal); endproperty
  property p_lat; wr2 && !(op inside {[4'h1:4'h6]}) |=> $stable(latency); endproperty
  property p_drv; wr3 && op inside {[4'h1:4'h7]} && op != 4'h5 |=> drive_strength == $past(op);
  endproperty
  a_rdv: assert property (p_rdv) else $error("read valid off");
  a_rdz: assert property (p_rdz) else $error("idle read data");
  a_clr: assert property (p_clr) else $error("flag not cleared");
  a_set: assert property (p_set) else $error("flag not set");
  a_rate: assert property (p_rate) else $error("rate field");
  a_der: assert property (p_der) else $error("derate");
  a_lim: assert property (p_lim) else $error("limit");
  a_cal: assert property (p_cal) else $error("cal pulse");
  a_lat: assert property (p_lat) else $error("latency changed");
  a_drv: assert property (p_drv) else $error("drive");
  c_rd4: cover property (rd4);
  c_cal: cover property (cal_start);
  c_der: cover property (derate_timing);
endmodule : sdmrf_monitor
bind sdmrf_regfile sdmrf_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n), .cmd(cmd),
  .sensor_rate(sensor_rate), .rd_data(rd_data), .rd_valid(rd_valid), .latency(latency),
  .drive_strength(drive_strength), .cal_start(cal_start), .derate_timing(derate_timing),
  .temp_limit_exceeded(temp_limit_exceeded));
`default_nettype wire

// >>> tb/sdmrf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Controller issuing mode register commands
// ----
module sdmrf_host_model (
  input  wire logic                 core_clk,
  input  wire logic [7:0]           rd_data,
  input  wire logic                 rd_valid,
  output var sdmrf_pkg::sdmrf_cmd_t cmd
);
  initial cmd = '0;
  task automatic issue(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge core_clk);
    cmd = '{wr: w, rd: !w, mode_address: a, opcode_bits: d};
    @(negedge core_clk);
    q = rd_valid ? rd_data : 8'hxx;
    cmd = '0;
  endtask : issue
endmodule : sdmrf_host_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  // ----
  // Harness
  // ----
  localparam logic [7:0] MK = 8'h3c;  // Arbitrary value
  localparam logic [7:0] RV1 = 8'h21; // Arbitrary value
  localparam logic [7:0] RV2 = 8'h4e; // Arbitrary value
  localparam logic [7:0] LT [6] = '{8'h31, 8'h42, 8'h52, 8'h63, 8'h74, 8'h84};
  localparam logic [7:0] CT [4] = '{8'hff, 8'hab, 8'h56, 8'hc3};
  logic core_clk = 0, rst_n = 0, rd_valid, cal_start, derate_timing, temp_limit_exceeded;
  logic [2:0] sensor_rate = 3'h3, r, p;
  logic [7:0] rd_data, q, el;
  logic [3:0] drive_strength, ed;
  sdmrf_pkg::sdmrf_cmd_t cmd;
  sdmrf_pkg::sdmrf_lat_t latency;
  sdmrf_pkg::sdmrf_cal_t cal_kind;
  int miscompares = 0, cmp_count = 0;
  always #5 core_clk = ~core_clk;
  sdmrf_regfile #(.MAKER_CODE(MK), .DIE_REV_CODE(RV1), .REV2_CODE(RV2), .DEV_TYPE(2'h1),
    .DENSITY(4'h9), .IO_WIDTH(2'h2)) dut (.core_clk(core_clk), .rst_n(rst_n), .cmd(cmd),
    .sensor_rate(sensor_rate), .rd_data(rd_data), .rd_valid(rd_valid), .latency(latency),
    .drive_strength(drive_strength), .cal_start(cal_start), .cal_kind(cal_kind),
    .derate_timing(derate_timing), .temp_limit_exceeded(temp_limit_exceeded));
  sdmrf_host_model host (.core_clk(core_clk), .rd_data(rd_data), .rd_valid(rd_valid), .cmd(cmd));
  task wr(input logic [7:0] a, d); host.issue(1'b1, a, d, q); endtask : wr
  task rd(input logic [7:0] a, e); host.issue(1'b0, a, 8'h00, q); `CHK(q, e) endtask : rd
  task tdone(input string s); $display("test %s done", s); endtask : tdone
  task give_verdict;
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    #100us;
    miscompares++;
    give_verdict;
  end
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (4) @(negedge core_clk);
    rst_n = 1;
    `CHK(latency, 8'h31)
    `CHK(drive_strength, 4'h2)
    rd(sdmrf_pkg::ADDR_TEMP_STATUS, 8'h03);
    rd(sdmrf_pkg::ADDR_LATENCY_SELECT, 8'h00);
    tdone("reset");
    el = 8'h31;
    ed = 4'h2;
    for (int i = 0; i < 16; i++) begin
      if (i >= 1 && i <= 6) el = LT[i-1];
      if (i >= 1 && i <= 7 && i != 5) ed = i[3:0];
      wr(sdmrf_pkg::ADDR_LATENCY_SELECT, i[7:0]);
      `CHK(latency, el)
      wr(sdmrf_pkg::ADDR_IO_DRIVE, i[7:0]);
      `CHK(drive_strength, ed)
    end
    rd(sdmrf_pkg::ADDR_IO_DRIVE, 8'h00);
    tdone("settings");
    p = 3'h3;
    for (int i = 0; i < 8; i++) begin
      r = i[2:0] ^ 3'h3;
      @(negedge core_clk);
      sensor_rate = r;
      rd(sdmrf_pkg::ADDR_TEMP_STATUS, {r != p, 4'h0, r});
      rd(sdmrf_pkg::ADDR_TEMP_STATUS, {5'h00, r});
      `CHK(derate_timing, r == 3'h6)
      `CHK(temp_limit_exceeded, r == 3'h0 || r == 3'h7)
      p = r;
    end
    tdone("temperature");
    @(negedge core_clk);
    sensor_rate = 3'h3;
    @(negedge core_clk);
    rst_n = 0;
    repeat (2) @(negedge core_clk);
    rst_n = 1;
    `CHK(latency, 8'h31)
    `CHK(drive_strength, 4'h2)
    rd(sdmrf_pkg::ADDR_TEMP_STATUS, 8'h03);
    tdone("midrun reset");
    wr(sdmrf_pkg::ADDR_MAKER_ID, 8'hff);
    rd(sdmrf_pkg::ADDR_MAKER_ID, MK);
    rd(sdmrf_pkg::ADDR_DIE_REV, RV1);
    rd(sdmrf_pkg::ADDR_SECOND_REV, RV2);
    rd(sdmrf_pkg::ADDR_GEOMETRY, 8'ha5);
    rd(sdmrf_pkg::ADDR_VENDOR_TEST, 8'h00);
    rd(8'h20, 8'h00);
    tdone("identity");
    for (int i = 0; i < 6; i++) begin
      wr(sdmrf_pkg::ADDR_CALIBRATION, i < 4 ? CT[i] : 8'h0c + i[7:0]);
      `CHK(cal_start, i < 4)
      `CHK(cal_kind, i < 4 ? i[1:0] : 2'h3)
    end
    tdone("calibration");
    give_verdict;
  end
endmodule : tb
`default_nettype wire
